/* File: core/swm_regs.sv */
/*
 Supply warning monitor register bank: Avalon-MM slave with
 waitrequest, threshold selection, crossing detection, sticky
 flag and level interrupt.
 Assumes a 250 MHz sys_clk_i, an analog comparator whose output
 is asynchronous, and detector mode and sample strobe from logic
 on the same clock.
*/
// Design decision made here: register access over Avalon-MM.
// Notes on behaviour
// - Read-only 3-bit trip level, loaded from non-volatile config after reset.
// - 2-bit margin puts warning 5, 15 or 25 percent above trip; 3 reserved.
// - Direction code: 0 falling, 1 rising, 2 either; 3 reserved, no trigger.
// - Bit 0 of interrupt control enables the warning interrupt.
// - Warning flag bit 0 sets on a crossing matching the direction.
// - Flag is held only while the detector is enabled; off clears it.
// - Read-only status bit: 0 above warning threshold, 1 below.
// - Control, flag and status reset to zero; upper bits read zero.
// - Interrupt asserts while flag and enable are set, gated by global enable.
// - Monitor follows detector mode: inactive when off, sampled when sampled.
`include "swm_params.svh"
`timescale 1ns/1ns
`default_nettype none
module swm_regs
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [2:0] nv_trip_level_i,
   input wire logic [1:0] brownout_mode_i,
   input wire logic brownout_sample_i,
   input wire logic comp_below_i,
   input wire logic global_irq_en_i,
   output swm_pkg::swm_thresh_t thresh_o,
   output logic irq_o
);
   import swm_pkg::*;

   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   swm_avreq_t req;
   logic [2:0] trip_threshold_sel;
   logic level_loaded;
   logic [1:0] warn_margin_sel;
   swm_dir_t warn_direction_sel;
   logic warn_irq_en;
   logic warn_irq_flag;
   logic below_warn_state;
   logic armed;
   logic [2:0] comp_sync;
   logic mon_active;
   logic mon_update;
   logic cmp_stable;
   logic crossing;
   logic fell;
   logic rose;
   logic hit;
   logic access;
   logic wr_take;
   logic [3:0] index;
   logic [7:0] next_rdata;

   assign req = '{address: avs_address_i, read: avs_read_i,
                  write: avs_write_i, writedata: avs_writedata_i,
                  byteenable: avs_byteenable_i};
   assign index = req.address[5:2];
   assign access = req.read | req.write;
   // Write lands at the edge where the master sees waitrequest low
   assign wr_take = req.write & ~avs_waitrequest_o & req.byteenable[0];

   // ----------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------
   // Waitrequest idles high, drops for one cycle per request
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         avs_waitrequest_o <= 1'b1;
      else if (access && avs_waitrequest_o)
         avs_waitrequest_o <= 1'b0;
      else
         avs_waitrequest_o <= 1'b1;
   end

   // Read mux; unmapped indices and upper bits read zero
   always_comb
   begin
      next_rdata = 8'h00;
      case (index)
         `SWM_IDX_LEVEL: next_rdata = {5'h00, trip_threshold_sel};
         `SWM_IDX_MARGIN: next_rdata = {6'h00, warn_margin_sel};
         `SWM_IDX_IRQ_CTRL:
            next_rdata = {5'h00, warn_direction_sel, warn_irq_en};
         `SWM_IDX_FLAGS: next_rdata = {7'h00, warn_irq_flag};
         `SWM_IDX_STATE: next_rdata = {7'h00, below_warn_state};
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data captured while waitrequest is still high
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (req.read && avs_waitrequest_o)
         avs_readdata_o <= {24'h00_0000, next_rdata};
   end

   // ----------------------------------------------------------
   // Trip level from non-volatile configuration
   // ----------------------------------------------------------
   // Caught once after release; the reset branch stays constant
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         trip_threshold_sel <= `SWM_RST_LEVEL;
         level_loaded <= 1'b0;
      end
      else if (!level_loaded)
      begin
         trip_threshold_sel <= nv_trip_level_i;
         level_loaded <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------
   // Reserved margin code is stored; the analog side treats it
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         warn_margin_sel <= `SWM_RST_MARGIN;
      else if (wr_take && index == `SWM_IDX_MARGIN)
         warn_margin_sel <= req.writedata[1:0];
   end

   // Interrupt control: enable and crossing direction
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         warn_irq_en <= 1'b0;
         warn_direction_sel <= SWM_DIR_FALL;
      end
      else if (wr_take && index == `SWM_IDX_IRQ_CTRL)
      begin
         warn_irq_en <= req.writedata[`SWM_IRQ_EN_BIT];
         warn_direction_sel <= swm_dir_t'(
            req.writedata[`SWM_DIR_MSB:`SWM_DIR_LSB]);
      end
   end

   // Threshold selection drives the analog comparator through one register stage
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         thresh_o <= '{trip_threshold_sel: `SWM_RST_LEVEL,
                       warn_margin_sel: `SWM_RST_MARGIN};
      else
         thresh_o <= '{trip_threshold_sel: trip_threshold_sel,
                       warn_margin_sel: warn_margin_sel};
   end

   // ----------------------------------------------------------
   // Comparator input and crossing detection
   // ----------------------------------------------------------
   // Three stages; only stages two and three are compared
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         comp_sync <= 3'h0;
      else
         comp_sync <= {comp_sync[1:0], comp_below_i};
   end

   assign cmp_stable = comp_sync[1] == comp_sync[2];
   // Detector off: monitor idle; sampled mode waits for a strobe
   assign mon_active = brownout_mode_i != 2'h0;
   assign mon_update = mon_active && cmp_stable &&
                       (brownout_mode_i != 2'h2 || brownout_sample_i);
   assign crossing = mon_update && armed &&
                     comp_sync[2] != below_warn_state;
   assign fell = crossing && comp_sync[2];
   assign rose = crossing && !comp_sync[2];

   // Direction match; the reserved code never triggers
   always_comb
   begin
      hit = 1'b0;
      case (warn_direction_sel)
         SWM_DIR_FALL: hit = fell;
         SWM_DIR_RISE: hit = rose;
         SWM_DIR_BOTH: hit = fell | rose;
         default: hit = 1'b0;
      endcase
   end

   // Live status; the first update after enabling only loads it,
   // so switching the detector on never fakes a crossing
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         below_warn_state <= 1'b0;
         armed <= 1'b0;
      end
      else if (!mon_active)
      begin
         below_warn_state <= 1'b0;
         armed <= 1'b0;
      end
      else if (mon_update)
      begin
         below_warn_state <= comp_sync[2];
         armed <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // Sticky flag and interrupt
   // ----------------------------------------------------------
   // A crossing in the clearing cycle wins over the clear
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         warn_irq_flag <= 1'b0;
      else if (!mon_active)
         warn_irq_flag <= 1'b0;
      else if (hit)
         warn_irq_flag <= 1'b1;
      else if (wr_take && index == `SWM_IDX_FLAGS &&
               req.writedata[`SWM_FLAG_BIT])
         warn_irq_flag <= 1'b0;
   end

   // Level request; global enable gates it without clearing it
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= warn_irq_flag & warn_irq_en & global_irq_en_i;
   end

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   wait_one_cycle_a: assert property
      (access && avs_waitrequest_o |=> !avs_waitrequest_o ##1
       avs_waitrequest_o)
      else $error("waitrequest not low for exactly one cycle");
   upper_zero_a: assert property
      (avs_readdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   level_load_a: assert property
      (level_loaded && $past(level_loaded) |->
       $stable(trip_threshold_sel))
      else $error("trip level changed after load");
   margin_write_a: assert property
      (wr_take && index == `SWM_IDX_MARGIN |=>
       warn_margin_sel == $past(req.writedata[1:0]))
      else $error("margin write not stored");
   irq_level_a: assert property
      (warn_irq_flag && warn_irq_en && global_irq_en_i |=> irq_o)
      else $error("interrupt missing");
   irq_gate_a: assert property
      (!warn_irq_flag || !warn_irq_en || !global_irq_en_i |=> !irq_o)
      else $error("interrupt without cause");
   flag_set_a: assert property
      (hit && mon_active |=> warn_irq_flag)
      else $error("flag not set on matching crossing");
   flag_off_a: assert property
      (!mon_active |=> !warn_irq_flag ##0 !below_warn_state)
      else $error("flag or status held with detector off");
   rsvd_dir_a: assert property
      (warn_direction_sel == SWM_DIR_RSVD && !warn_irq_flag &&
       !(wr_take && index == `SWM_IDX_IRQ_CTRL) |=> !warn_irq_flag)
      else $error("reserved direction raised the flag");
   clear_zero_a: assert property
      (warn_irq_flag && mon_active && wr_take &&
       index == `SWM_IDX_FLAGS && !req.writedata[0] |=> warn_irq_flag)
      else $error("write of zero cleared the flag");
   status_follow_a: assert property
      (mon_update |=> below_warn_state == $past(comp_sync[2]))
      else $error("status does not follow comparator");

   fall_irq_c: cover property (fell ##[1:4] irq_o);
   rise_flag_c: cover property
      (warn_direction_sel == SWM_DIR_RISE && rose ##1 warn_irq_flag);
   clear_c: cover property
      (warn_irq_flag ##1 !warn_irq_flag && mon_active);
   sampled_c: cover property (brownout_mode_i == 2'h2 && crossing);
endmodule // swm_regs
`default_nettype wire

/* File: core/swm_params.svh */
/*
 Constants of the supply warning monitor register bank: register
 indices, field positions, reset values and threshold codes.
 Assumes inclusion by bare name from the package and the design.
*/
`ifndef SWM_PARAMS_SVH
`define SWM_PARAMS_SVH
// -------------------------------------------------------------
// Register indices (byte address is four times the index)
// -------------------------------------------------------------
`define SWM_IDX_LEVEL 4'h1
`define SWM_IDX_MARGIN 4'h8
`define SWM_IDX_IRQ_CTRL 4'h9
`define SWM_IDX_FLAGS 4'ha
`define SWM_IDX_STATE 4'hb
// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define SWM_IRQ_EN_BIT 0
`define SWM_DIR_LSB 1
`define SWM_DIR_MSB 2
`define SWM_FLAG_BIT 0
`define SWM_STATE_BIT 0
// -------------------------------------------------------------
// Reset values and codes
// -------------------------------------------------------------
`define SWM_RST_MARGIN 2'h0
`define SWM_RST_DIR 2'h0
`define SWM_RST_LEVEL 3'h0
`define SWM_LOWEST_TRIP_CODE 3'h0
`define SWM_HIGHEST_TRIP_CODE 3'h7
`define SWM_MARGIN_5PCT 2'h0
`define SWM_MARGIN_15PCT 2'h1
`define SWM_MARGIN_25PCT 2'h2
`endif

/* File: core/swm_pkg.sv */
/*
 Types of the supply warning monitor register bank.
 Assumes swm_params.svh sits beside this file.
*/
`include "swm_params.svh"
package swm_pkg;
   // Crossing direction codes; the fourth code is reserved
   typedef enum logic [1:0]
   {
      SWM_DIR_FALL = 2'h0,
      SWM_DIR_RISE = 2'h1,
      SWM_DIR_BOTH = 2'h2,
      SWM_DIR_RSVD = 2'h3
   } swm_dir_t;
   // Threshold selection carried to the analog comparator
   typedef struct packed
   {
      logic [2:0] trip_threshold_sel;
      logic [1:0] warn_margin_sel;
   } swm_thresh_t;
   // Avalon request as seen by the slave
   typedef struct packed
   {
      logic [5:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } swm_avreq_t;
endpackage

/* File: verification/tb_supply_warning_monitor_regs.sv */
/*
 Self-checking bench for the supply warning monitor register bank:
 reset values, margin and direction fields, sticky flag, interrupt.
 Assumes swm_pkg is compiled first; assertions live in the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_supply_warning_monitor_regs;
   import swm_pkg::*;
   localparam logic [2:0] NV_LEVEL = 3'h5;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] adr = 6'h00;
   logic avs_rd = 1'b0;
   logic avs_wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [1:0] mode = 2'h1;
   logic smp = 1'b0;
   logic comp = 1'b0;
   logic gie = 1'b1;
   logic [3:0] be = 4'h1;
   logic [31:0] rdata;
   logic wait_q;
   swm_thresh_t thresh;
   logic irq;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   // -------------------------------------------------------------
   // Clock, design and timeout
   // -------------------------------------------------------------
   always #2 sys_clk_i = ~sys_clk_i;
   swm_regs dut
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .avs_address_i(adr),
      .avs_read_i(avs_rd),
      .avs_write_i(avs_wr),
      .avs_writedata_i(wdata),
      .avs_byteenable_i(be),
      .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_q),
      .nv_trip_level_i(NV_LEVEL),
      .brownout_mode_i(mode),
      .brownout_sample_i(smp),
      .comp_below_i(comp),
      .global_irq_en_i(gie),
      .thresh_o(thresh),
      .irq_o(irq)
   );
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; a hang is left
   // to the cycle ceiling, so no wait length is assumed here
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk_i);
      adr <= a;
      avs_wr <= w;
      avs_rd <= !w;
      wdata <= {24'h0, d};
      do
      begin
         @(posedge sys_clk_i);
      end
      while (wait_q !== 1'b0);
      q = rdata[7:0];
      if (!w) chk({7'h0, |rdata[31:8]}, 8'h00);
      avs_rd <= 1'b0;
      avs_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic wt(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   // Comparator passes three flops before status and flag move
   task automatic move(input logic v);
      @(posedge sys_clk_i);
      comp <= v;
      repeat (8) @(posedge sys_clk_i);
   endtask
   task automatic pulse();
      @(posedge sys_clk_i);
      smp <= 1'b1;
      @(posedge sys_clk_i);
      smp <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      rd(6'h04, {5'h0, NV_LEVEL});
      chk({5'h0, thresh.trip_threshold_sel}, {5'h0, NV_LEVEL});
      rd(6'h20, 8'h00);
      rd(6'h24, 8'h00);
      rd(6'h28, 8'h00);
      rd(6'h2c, 8'h00);
      wt(6'h04, 8'h02);
      rd(6'h04, {5'h0, NV_LEVEL});
      wt(6'h2c, 8'hff);
      rd(6'h2c, 8'h00);
      wt(6'h3c, 8'hff);
      rd(6'h3c, 8'h00);
   endtask
   task automatic t_margin();
      for (int c = 0; c < 3; c++)
      begin
         wt(6'h20, 8'(c));
         rd(6'h20, 8'(c));
         chk({6'h0, thresh.warn_margin_sel}, 8'(c));
      end
      wt(6'h20, 8'hff);
      rd(6'h20, 8'h03);
   endtask
   // Falling crossing with interrupt enabled, then gating and clear
   task automatic t_fall();
      wt(6'h24, 8'h01);
      rd(6'h24, 8'h01);
      move(1'b1);
      rd(6'h2c, 8'h01);
      rd(6'h28, 8'h01);
      chk({7'h0, irq}, 8'h01);
      gie <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk({7'h0, irq}, 8'h00);
      gie <= 1'b1;
      wt(6'h28, 8'h00);
      rd(6'h28, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wt(6'h28, 8'h01);
      rd(6'h28, 8'h00);
      repeat (2) @(posedge sys_clk_i);
      chk({7'h0, irq}, 8'h00);
   endtask
   // Rising, either and reserved direction codes, enable off
   task automatic t_dirs();
      wt(6'h24, 8'h02);
      move(1'b0);
      rd(6'h28, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wt(6'h28, 8'h01);
      move(1'b1);
      rd(6'h28, 8'h00);
      wt(6'h24, 8'h04);
      move(1'b0);
      rd(6'h28, 8'h01);
      wt(6'h28, 8'h01);
      move(1'b1);
      rd(6'h28, 8'h01);
      wt(6'h28, 8'h01);
      wt(6'h24, 8'h06);
      move(1'b0);
      rd(6'h28, 8'h00);
   endtask
   // Detector off clears flag and status and ignores crossings
   task automatic t_off();
      wt(6'h24, 8'h05);
      move(1'b1);
      chk({7'h0, irq}, 8'h01);
      mode <= 2'h0;
      repeat (4) @(posedge sys_clk_i);
      chk({7'h0, irq}, 8'h00);
      rd(6'h28, 8'h00);
      rd(6'h2c, 8'h00);
      move(1'b0);
      rd(6'h28, 8'h00);
   endtask
   // Sampled mode moves only on the detector's sample strobe
   task automatic t_sampled();
      mode <= 2'h2;
      pulse();
      move(1'b1);
      rd(6'h2c, 8'h00);
      rd(6'h28, 8'h00);
      pulse();
      rd(6'h2c, 8'h01);
      rd(6'h28, 8'h01);
   endtask
   // Mode 3 runs like mode 1; a write with byte lane 0 off is ignored
   task automatic t_mode3();
      wt(6'h28, 8'h01);
      mode <= 2'h3;
      move(1'b0);
      rd(6'h2c, 8'h00);
      rd(6'h28, 8'h01);
      be <= 4'h0;
      wt(6'h20, 8'h01);
      be <= 4'h1;
      rd(6'h20, 8'h03);
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      t_reset();
      t_margin();
      t_fall();
      t_dirs();
      t_off();
      t_sampled();
      t_mode3();
      complete_run();
   end
endmodule // tb_supply_warning_monitor_regs
`default_nettype wire
